// File: hdl/portrait_pkg.sv
// Constants, modes and state layout for the rotated portrait refresh path
// Function
// - Only one screen region, no split screen
// - Default scheme: pixel rate equals core clock
// - Alternate scheme: core clock twice pixel clock
// - Select zero in default: memory clock halved
// - Default scheme pans in two-line steps
// - Alternate scheme pans in one-line steps
// - Control bit 2 runs memory at core rate
// - Memory contents never rotated by hardware
// - Control 80h selects default scheme
// - Control C0h selects alternate scheme
// - Offset zero is portrait upper-left pixel
// - Alternate stride equals width, no padding
// - Pixel select bits divide pixel clock further
// - Portrait start address is a byte offset
// - Enable clear: landscape, portrait settings ignored
// - Memory clock raised during each host access
package portrait_pkg;

  localparam int          ADDR_W          = 17;    // Display memory byte address width
  localparam int          CNT_W           = 10;    // Timing counter width
  localparam int          DIV_W           = 4;     // Pixel divider width

  // Portrait control byte fields
  localparam int          CTRL_EN_BIT     = 7;     // Portrait enable
  localparam int          CTRL_ALT_BIT    = 6;     // Alternate scheme select
  localparam int          CTRL_MCLK_BIT   = 2;     // Memory clock select
  localparam int          CTRL_PSEL_LSB   = 0;     // Pixel clock select, two bits
  localparam logic [7:0]  CTRL_DEFAULT    = 8'h80; // Default scheme, no extras
  localparam logic [7:0]  CTRL_ALTERNATE  = 8'hC0; // Alternate scheme, no extras

  // Base pixel divide ratios (log2) per scheme
  localparam logic [1:0]  DIV_LOG_DEFAULT = 2'h0;  // Pixel rate = core clock
  localparam logic [1:0]  DIV_LOG_ALT     = 2'h1;  // Pixel rate = core clock / 2

  // Timing
  localparam int          CORE_CLK_MHZ    = 25;    // Core clock rate
  localparam int          ALT_MAX_PIX_KHZ = 12500; // Alternate pixel clock ceiling
  localparam int          ALT_MIN_RATIO   = (CORE_CLK_MHZ * 1000) / ALT_MAX_PIX_KHZ;

  // Refresh modes, Gray coded
  typedef enum logic [1:0] {
    MODE_LANDSCAPE = 2'h0,
    MODE_DEFAULT   = 2'h1,
    MODE_ALTERNATE = 2'h3
  } mode_t;

  // Whole module state
  typedef struct packed {
    logic [CNT_W-1:0]  h_cnt;       // Pixel position in line
    logic [CNT_W-1:0]  v_cnt;       // Line position in frame
    logic [DIV_W-1:0]  div_cnt;     // Pixel divider
    logic              mclk_phase;  // Slow memory clock phase
    logic [ADDR_W-1:0] line_addr;   // First fetch of current line
    logic [ADDR_W-1:0] pix_addr;    // Next fetch address
    logic              rd_en;       // Fetch strobe
    logic [ADDR_W-1:0] rd_addr;     // Fetch address
    logic [7:0]        pix_data;    // Pixel byte to panel
    logic              pix_valid;   // Pixel byte strobe
    logic              line_start;  // First pixel of line
    logic              frame_start; // First pixel of frame
    logic              disp_active; // Active window
    logic              mclk_en;     // Memory clock enable
  } state_t;

  localparam state_t STATE_RESET = '0; // All state clear after reset

endpackage : portrait_pkg

// File: hdl/portrait_rotation_refresh.sv
// Rotated portrait refresh: pixel timing, rotated fetch and memory clock control
`timescale 1ns/1ps
module portrait_rotation_refresh (
  input  wire logic                          core_clk,           // 25 MHz core clock
  input  wire logic                          resetn,             // Async reset, active low
  input  wire logic [7:0]                    portrait_ctrl,      // Portrait control byte
  input  wire logic [portrait_pkg::ADDR_W-1:0] start_addr,       // Screen start address
  input  wire logic [7:0]                    line_byte_count,    // Portrait stride in bytes
  input  wire logic [portrait_pkg::CNT_W-1:0] horiz_active_period, // Pixels per line
  input  wire logic [portrait_pkg::CNT_W-1:0] horiz_blank_period,  // Blank pixels per line
  input  wire logic [portrait_pkg::CNT_W-1:0] vert_active_period,  // Lines per frame
  input  wire logic [portrait_pkg::CNT_W-1:0] vert_blank_period,   // Blank lines per frame
  input  wire logic                          host_access,        // Host access in progress
  input  wire logic [7:0]                    mem_rd_data,        // Read data, valid in the strobe cycle
  output logic                               mem_rd_en,          // Display memory read
  output logic [portrait_pkg::ADDR_W-1:0]    mem_rd_addr,        // Display memory byte address
  output logic [7:0]                         pixel_data,         // Pixel byte to panel
  output logic                               pixel_valid,        // Pixel byte strobe
  output logic                               line_start,         // First pixel of a line
  output logic                               frame_start,        // First pixel of a frame
  output logic                               display_active,     // Active window flag
  output logic                               mem_clk_en          // Memory clock enable
);
  import portrait_pkg::*;

  // Refresh flow: a divider gives one pixel tick per pixel period, and each
  // tick inside the active window issues one byte fetch; the byte reaches the
  // panel port on the following cycle.
  // Portrait order: a panel line walks one byte column of the host image,
  // stepping by the stride per pixel; the next panel line starts one byte
  // to the left, so the last line begins at offset zero.
  // Nothing here moves stored pixels: an image written before the switch
  // shows up unrotated until the host rewrites it.
  // Limitation: one screen region only, there is no second start address.
  // Hazard: the stride is read live, so changing it while a frame is shown tears
  // the picture; the start address is taken only at frame end. Change them in vertical blanking.

  // Refuse a divider too narrow for the largest ratio
  if (DIV_W < 4) begin : g_div_chk
    $error("Pixel divider too narrow");
  end

  // Stride and start masks are built from an 8-bit count
  if (ADDR_W <= 8) begin : g_addr_chk
    $error("Address too narrow for the stride");
  end

  // Alternate base divide must meet the core to pixel clock ceiling
  if ((1 << DIV_LOG_ALT) < ALT_MIN_RATIO) begin : g_alt_chk
    $error("Alternate divide below clock ceiling");
  end

  // Decode, timing and address nets
  state_t            state_reg;   // Registered state
  state_t            state_next;  // Next state
  mode_t             mode;        // Decoded refresh mode
  logic [1:0]        pix_sel;     // Extra pixel clock divide
  logic [2:0]        div_log;     // Total divide ratio, log2
  logic [DIV_W-1:0]  div_top;     // Divider terminal count
  logic              pix_en;      // One pixel period elapsed
  logic [CNT_W-1:0]  h_total;     // Line length in pixels
  logic [CNT_W-1:0]  v_total;     // Frame length in lines
  logic [ADDR_W-1:0] start_eff;   // Start after panning alignment
  logic [ADDR_W-1:0] stride;      // Byte step between pixels of a line
  logic [ADDR_W-1:0] frame_base;  // First fetch of a frame
  logic [ADDR_W-1:0] next_line;   // First fetch of next line
  logic              h_wrap;      // Last pixel of line
  logic              v_wrap;      // Last line of frame
  logic              active;      // Current pixel inside window

  // Mode decode; portrait settings ignored while enable is clear
  always_comb begin
    if (!portrait_ctrl[CTRL_EN_BIT]) begin
      mode = MODE_LANDSCAPE;
    end else if (portrait_ctrl[CTRL_ALT_BIT]) begin
      mode = MODE_ALTERNATE;
    end else begin
      mode = MODE_DEFAULT;
    end
  end

  // Pixel divider ratio and address stepping per mode
  always_comb begin
    pix_sel = portrait_ctrl[CTRL_PSEL_LSB +: 2];
    // Landscape walks linearly from a word start
    unique case (mode)
      MODE_LANDSCAPE: begin
        div_log   = {1'b0, DIV_LOG_DEFAULT};
        start_eff = start_addr;
        stride    = {{(ADDR_W-1){1'b0}}, 1'b1};
        // Word offset becomes a byte address
        frame_base = {start_addr[ADDR_W-2:0], 1'b0};
      end
      MODE_DEFAULT: begin
        div_log = {1'b0, DIV_LOG_DEFAULT} + {1'b0, pix_sel};
        // Drop the odd-line part so panning moves two lines at a time
        start_eff  = start_addr & ~{{(ADDR_W-8){1'b0}}, line_byte_count};
        // Stride is the padded power-of-two count
        stride     = {{(ADDR_W-8){1'b0}}, line_byte_count};
        frame_base = start_eff;
      end
      MODE_ALTERNATE: begin
        div_log    = {1'b0, DIV_LOG_ALT} + {1'b0, pix_sel};
        // Start used whole, so panning moves one line at a time
        start_eff  = start_addr;
        stride     = {{(ADDR_W-8){1'b0}}, line_byte_count};
        frame_base = start_eff;
      end
    endcase
  end

  // Divider terminal count and timing totals
  always_comb begin
    // Divider counts up to the terminal value, then ticks
    div_top = DIV_W'((1 << div_log) - 1);
    pix_en  = (state_reg.div_cnt >= div_top);
    h_total = horiz_active_period + horiz_blank_period;
    v_total = vert_active_period + vert_blank_period;
    // Counters wrap one short of the totals
    h_wrap  = (state_reg.h_cnt >= h_total - CNT_W'(1));
    v_wrap  = (state_reg.v_cnt >= v_total - CNT_W'(1));
    // Window is the leading corner of the line and the frame
    active  = (state_reg.h_cnt < horiz_active_period) &&
              (state_reg.v_cnt < vert_active_period);
  end

  // First fetch of the next line
  always_comb begin
    if (v_wrap) begin
      // Single screen region only, always from the one start address
      next_line = frame_base;
    end else if (mode == MODE_LANDSCAPE) begin
      next_line = state_reg.line_addr + ADDR_W'(horiz_active_period);
    end else begin
      // Each panel line walks one byte column leftward
      next_line = state_reg.line_addr - ADDR_W'(1);
    end
  end

  // Next state
  always_comb begin
    // Pulses fall unless a tick raises them
    state_next             = state_reg;
    state_next.rd_en       = 1'b0;
    state_next.pix_valid   = state_reg.rd_en;
    state_next.line_start  = 1'b0;
    state_next.frame_start = 1'b0;

    // Memory never written here, so old contents show unrotated
    state_next.pix_data = state_reg.rd_en ? mem_rd_data : state_reg.pix_data;

    // Memory clock: full rate in alternate, with select bit, or on host access
    // Phase flips every cycle, so a slow enable is high every other cycle
    state_next.mclk_phase = ~state_reg.mclk_phase;
    if (mode == MODE_ALTERNATE) begin
      state_next.mclk_en = 1'b1;
    end else if (mode != MODE_LANDSCAPE && portrait_ctrl[CTRL_MCLK_BIT]) begin
      state_next.mclk_en = 1'b1;
    end else if (mode != MODE_LANDSCAPE && host_access) begin
      state_next.mclk_en = 1'b1;
    end else if (mode != MODE_LANDSCAPE) begin
      state_next.mclk_en = state_reg.mclk_phase;
    end else begin
      state_next.mclk_en = 1'b1;
    end

    // Pixel divider
    // Restarts at each tick, so a ratio change takes effect at once
    if (pix_en) begin
      state_next.div_cnt = '0;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + DIV_W'(1);
    end

    // One pixel period per divider wrap
    if (pix_en) begin
      state_next.disp_active = active;
      // Fetch only inside the window
      if (active) begin
        state_next.rd_en       = 1'b1;
        state_next.rd_addr     = state_reg.pix_addr;
        state_next.pix_addr    = state_reg.pix_addr + stride;
        state_next.line_start  = (state_reg.h_cnt == '0);
        state_next.frame_start = (state_reg.h_cnt == '0) && (state_reg.v_cnt == '0);
      end
      // Line end: reload the pointer from the next line start
      if (h_wrap) begin
        state_next.h_cnt     = '0;
        state_next.line_addr = next_line;
        state_next.pix_addr  = next_line;
        // Frame end restarts the line count
        if (v_wrap) begin
          state_next.v_cnt = '0;
        end else begin
          state_next.v_cnt = state_reg.v_cnt + CNT_W'(1);
        end
      end else begin
        state_next.h_cnt = state_reg.h_cnt + CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Counters, pointers and pulses all clear
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state flops; line 0 pixel 0 is portrait top right,
  // last line begins at offset zero, the portrait upper left
  assign mem_rd_en      = state_reg.rd_en;
  assign mem_rd_addr    = state_reg.rd_addr;
  assign pixel_data     = state_reg.pix_data;
  assign pixel_valid    = state_reg.pix_valid;
  assign line_start     = state_reg.line_start;
  assign frame_start    = state_reg.frame_start;
  assign display_active = state_reg.disp_active;
  assign mem_clk_en     = state_reg.mclk_en;

endmodule : portrait_rotation_refresh

// File: test/refresh_sva.sv
// Checker on the rotated refresh path ports
`timescale 1ns/1ps
module refresh_sva (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] portrait_ctrl,
  input wire logic       host_access,
  input wire logic [7:0] mem_rd_data,
  input wire logic       mem_rd_en,
  input wire logic [7:0] pixel_data,
  input wire logic       pixel_valid,
  input wire logic       line_start,
  input wire logic       frame_start,
  input wire logic       mem_clk_en,
  input wire logic       display_active
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Memory clock enable per mode
  alt_mclk_a: assert property (portrait_ctrl[7:6] == 2'h3 |=> mem_clk_en)
    else $error("slow memory clock in alternate");
  sel_mclk_a: assert property (portrait_ctrl[7] && portrait_ctrl[2] |=> mem_clk_en)
    else $error("slow memory clock with select");
  host_mclk_a: assert property (portrait_ctrl == 8'h80 && host_access |=> mem_clk_en)
    else $error("slow memory clock in host access");
  slow_mclk_a: assert property ((portrait_ctrl == 8'h80 && !host_access)[*2]
    |=> mem_clk_en != $past(mem_clk_en)) else $error("memory clock not halved");
  land_mclk_a: assert property (!portrait_ctrl[7] |=> mem_clk_en)
    else $error("slow memory clock in landscape");
  // Pixel spacing after a line start, once the mode has settled
  def_rate_a: assert property (portrait_ctrl == 8'h80 && $past(portrait_ctrl, 4) == 8'h80
    && line_start |=> mem_rd_en) else $error("default pixel period not one");
  alt_rate_a: assert property (portrait_ctrl == 8'hC0 && $past(portrait_ctrl, 4) == 8'hC0
    && line_start |=> !mem_rd_en ##1 mem_rd_en) else $error("alternate pixel period not two");
  // Fetched byte reaches the panel one cycle later
  fetch_data_a: assert property (mem_rd_en |=> pixel_valid
    && pixel_data == $past(mem_rd_data)) else $error("pixel byte lost");
  frame_line_a: assert property (frame_start |-> line_start && mem_rd_en)
    else $error("frame start off line start");
  // Every fetch lies inside the active window
  window_fetch_a: assert property (mem_rd_en |-> display_active)
    else $error("fetch outside active window");
endmodule : refresh_sva
bind portrait_rotation_refresh refresh_sva u_sva (.core_clk, .resetn, .portrait_ctrl,
  .host_access, .mem_rd_data, .mem_rd_en, .pixel_data, .pixel_valid, .line_start,
  .frame_start, .mem_clk_en, .display_active);

// File: test/refresh_far_model.sv
// Display memory model on the far side of the fetch port
`timescale 1ns/1ps
module refresh_far_model (
  input  wire logic                            core_clk,
  input  wire logic                            mem_rd_en,
  input  wire logic [portrait_pkg::ADDR_W-1:0] mem_rd_addr,
  output logic      [7:0]                      mem_rd_data
);
  import portrait_pkg::*;
  logic [7:0] held = 8'h00; // Byte kept one cycle, then scrambled
  logic       hold = 1'b0;  // Byte still valid
  // Data valid with the strobe and one cycle after, else changing garbage
  always_ff @(posedge core_clk) begin
    hold <= mem_rd_en;
    held <= mem_rd_en ? (mem_rd_addr[7:0] ^ 8'hA5) : ~held;
  end
  assign mem_rd_data = mem_rd_en ? (mem_rd_addr[7:0] ^ 8'hA5) : (hold ? held : ~held);
endmodule : refresh_far_model

// File: test/portrait_rotation_refresh_tb.sv
// Self-checking bench for the rotated portrait refresh path
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module portrait_rotation_refresh_tb;
  import portrait_pkg::*;
  localparam int HACT = 4; // Tiny panel keeps frames short
  localparam int HBLK = 3;
  localparam int VACT = 3;
  localparam int VBLK = 2;
  logic              core_clk = 1'b0;
  logic              resetn = 1'b0;
  logic [7:0]        portrait_ctrl = 8'h00;
  logic [ADDR_W-1:0] start_addr = '0;
  logic [7:0]        line_byte_count = 8'h00;
  logic              host_access = 1'b0;
  logic [7:0]        mem_rd_data, pixel_data;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic              mem_rd_en, pixel_valid, line_start, frame_start, display_active, mem_clk_en;
  logic [24:0]       exp_q[$]; // Expected gap and address per fetch
  logic [24:0]       exp_w;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                gap = 0;
  bit                armed = 1'b0;
  logic [7:0]        ctrl_tab[7] = '{CTRL_DEFAULT, CTRL_ALTERNATE, 8'h81, 8'hC2, 8'h84,
                                     8'h44, 8'h83};
  int                per_tab[7] = '{1, 2, 2, 8, 1, 1, 8};
  initial forever #20 core_clk = ~core_clk;
  portrait_rotation_refresh uut (.core_clk, .resetn, .portrait_ctrl, .start_addr,
    .line_byte_count, .horiz_active_period(CNT_W'(HACT)), .horiz_blank_period(CNT_W'(HBLK)),
    .vert_active_period(CNT_W'(VACT)), .vert_blank_period(CNT_W'(VBLK)), .host_access,
    .mem_rd_data, .mem_rd_en, .mem_rd_addr, .pixel_data, .pixel_valid, .line_start,
    .frame_start, .display_active, .mem_clk_en);
  refresh_far_model far (.core_clk, .mem_rd_en, .mem_rd_addr, .mem_rd_data);
  // Verdict and end of run
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Random host accesses and hang guard
  always @(posedge core_clk) begin
    cycles++;
    host_access <= ($urandom % 4) == 0;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // Compare each fetch of an armed frame with the oldest note
  always @(negedge core_clk) begin
    gap++;
    if (mem_rd_en && exp_q.size() > 0 && (armed || frame_start)) begin
      exp_w = exp_q.pop_front();
      `CHECK({(exp_w[24:17] == 8'h00) ? 8'h00 : 8'(gap), mem_rd_addr}, exp_w)
      armed = exp_q.size() > 0;
    end
    if (mem_rd_en) gap = 0;
  end
  // Program one mode, time a frame, then note one frame of fetches
  task automatic run_mode(input logic [7:0] ctrl, input int per);
    logic [ADDR_W-1:0] st;
    logic [ADDR_W-1:0] base;
    logic [7:0]        lbc;
    int                n;
    lbc = ctrl[6] ? 8'(1 + $urandom % 200) : 8'h08 << ($urandom % 4);
    // Half the runs start at the stride minus one, the rest anywhere below 4000h
    st = ($urandom % 2) ? ADDR_W'(lbc) - ADDR_W'(1) : ADDR_W'($urandom % 32'h4000);
    portrait_ctrl <= ctrl;
    start_addr <= st;
    line_byte_count <= lbc;
    base = !ctrl[7] ? ADDR_W'(2 * st) : (ctrl[6] ? st : st & ~ADDR_W'(lbc));
    repeat (3) begin
      n = 0;
      do begin
        @(negedge core_clk);
        n++;
      end while (frame_start !== 1'b1 && n < 2000);
    end
    `CHECK(n, (HACT + HBLK) * (VACT + VBLK) * per)
    @(negedge core_clk);
    for (int l = 0; l < VACT; l++) begin
      for (int p = 0; p < HACT; p++) begin
        exp_q.push_back({(p == 0) ? 8'h00 : 8'(per), ctrl[7] ? ADDR_W'(base - l + p * lbc)
                         : ADDR_W'(base + l * HACT + p)});
      end
    end
    n = 0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK(exp_q.size(), 0)
    exp_q.delete();
  endtask : run_mode
  // Reset, then every mode of the table
  initial begin
    void'($urandom(32'h694e));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      run_mode(ctrl_tab[i], per_tab[i]);
    end
    final_report();
  end
endmodule : portrait_rotation_refresh_tb
